// File: rss_consts.svh
// Register map, field positions, reset values and timing figures.
`ifndef RSS_CONSTS_SVH
`define RSS_CONSTS_SVH

// ========================================
// Register byte offsets
`define RSS_OFS_HARDWARE_CONFIG_REG      9'h004
`define RSS_OFS_POWER_MGMT_CTRL_REG    9'h008
`define RSS_OFS_BYTE_TEST   9'h00C
`define RSS_OFS_HOST_SCR    9'h010
`define RSS_OFS_RESET_CONTROL_REG   9'h1F0
`define RSS_OFS_STICKY      9'h1F4

// ========================================
// Field positions
`define RSS_HW_SOFT_BIT     0
`define RSS_HW_STRAP_LSB    8
`define RSS_HW_READY_BIT    27
`define RSS_PMT_READY_BIT   0
`define RSS_PMT_VPHY_BIT    4
`define RSS_RC_DIG_BIT      0
`define RSS_RC_PHY1_BIT     1
`define RSS_RC_PHY2_BIT     2
`define RSS_RC_VPHY_BIT     3

// ========================================
// Reset values
`define RSS_RST_WORD        32'h0000_0000
`define RSS_BYTE_TEST_VAL   32'h5A3C_96E1

// ========================================
// Timing figures, as printed, and clock rate
`define RSS_CLK_KHZ         25000
`define RSS_POR_MS          23
`define RSS_PIN_US          760
`define RSS_DIG_US          760
`define RSS_SOFT_US         590
`define RSS_PHY_US          110
`define RSS_VPHY_US         1

`endif

// File: rss_loader_model.sv
// Behavioural loader that answers a start pulse after a set delay.
`timescale 1ns/1ps

module rss_loader_model (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    input  wire logic       i_start,
    input  wire logic [7:0] i_dly,
    output logic            o_done
);

    int cnt;

    // ========================================
    // Load time stands in for the per-byte cost; delay set per test
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            cnt    <= 0;
            o_done <= 1'b0;
        end else begin
            o_done <= (cnt == 1);
            if (i_start) begin
                cnt <= int'(i_dly);
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
        end
    end

endmodule

// File: rss_pkg.sv
// Types shared by the reset source sequencer.
package rss_pkg;

    // ========================================
    // Sequencer states
    typedef enum logic [1:0] {
        RSS_READY,
        RSS_HOLD,
        RSS_LOAD
    } rss_state_t;

    // ========================================
    // Kind of reset in progress
    typedef enum logic [1:0] {
        RSS_KIND_POR,
        RSS_KIND_PIN,
        RSS_KIND_DIG,
        RSS_KIND_SOFT
    } rss_kind_t;

endpackage

// File: rss_sync.sv
// Two-flop synchroniser for pin inputs.
`timescale 1ns/1ps

module rss_sync #(
    parameter int          W       = 1,
    parameter logic        RST_VAL = 1'b0
) (
    input  wire logic         i_clk_sys,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    logic [W-1:0] meta;

    // ========================================
    // First stage feeds only the second stage
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            meta   <= {W{RST_VAL}};
            o_sync <= {W{RST_VAL}};
        end else begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end

endmodule

// File: rss_top.sv
// Reset source sequencer with a classic Wishbone register slave.
//
// The Wishbone slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "rss_consts.svh"

module rss_top #(
    parameter int SW        = 4,
    parameter int CW        = 20,
    parameter int POR_CYC   = (`RSS_POR_MS * `RSS_CLK_KHZ),
    parameter int PIN_CYC   = (`RSS_PIN_US * `RSS_CLK_KHZ + 999) / 1000,
    parameter int DIG_CYC   = (`RSS_DIG_US * `RSS_CLK_KHZ + 999) / 1000,
    parameter int SOFT_CYC  = (`RSS_SOFT_US * `RSS_CLK_KHZ + 999) / 1000,
    parameter int PHY_CYC   = (`RSS_PHY_US * `RSS_CLK_KHZ + 999) / 1000,
    parameter int VPHY_CYC  = (`RSS_VPHY_US * `RSS_CLK_KHZ + 999) / 1000,
    // Arbitrary pattern for the byte-order test register
    parameter logic [31:0] BYTE_TEST = `RSS_BYTE_TEST_VAL
) (
    input  wire logic          i_clk_sys,
    input  wire logic          i_rst,
    input  wire logic          i_pin_reset_low,
    input  wire logic [SW-1:0] i_strap,
    input  wire logic          i_loader_done,
    input  wire logic          i_wb_cyc,
    input  wire logic          i_wb_stb,
    input  wire logic          i_wb_we,
    input  wire logic [8:0]    i_wb_adr,
    input  wire logic [31:0]   i_wb_dat,
    input  wire logic [3:0]    i_wb_sel,
    output logic      [31:0]   o_wb_dat,
    output logic               o_wb_ack,
    output logic               o_rst_chip,
    output logic               o_rst_digital,
    output logic               o_rst_host,
    output logic               o_rst_phy1,
    output logic               o_rst_phy2,
    output logic               o_rst_vphy,
    output logic      [SW-1:0] o_strap_q,
    output logic               o_loader_start,
    output logic               o_loader_mac_only,
    output logic               o_ready
);

    // ========================================
    // Elaboration checks
    localparam logic [CW-1:0] CMAX = {CW{1'b1}};
    generate
        if (SW < 1 || SW > 16) begin : g_bad_sw
            $error("strap width must be 1 to 16");
        end
        if (CW < 2 || CW > 31) begin : g_bad_cw
            $error("counter width must be 2 to 31");
        end
        if (POR_CYC < 1 || PIN_CYC < 1 || DIG_CYC < 1 || SOFT_CYC < 1 ||
            PHY_CYC < 1 || VPHY_CYC < 1) begin : g_bad_min
            $error("every reset time needs at least one cycle");
        end
        if (POR_CYC > 2**CW - 1 || PIN_CYC > 2**CW - 1 ||
            DIG_CYC > 2**CW - 1 || SOFT_CYC > 2**CW - 1 ||
            PHY_CYC > 2**CW - 1 || VPHY_CYC > 2**CW - 1) begin : g_bad_max
            $error("a reset time does not fit the counter");
        end
    endgenerate

    // ========================================
    // Helpers
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [CW-1:0] phy_time(input int idx);
        logic [CW-1:0] t;
        t = (idx == 2) ? CW'(VPHY_CYC) : CW'(PHY_CYC);
        return t;
    endfunction

    // ========================================
    // Pin inputs through two flops
    logic          pin_high;
    logic [SW-1:0] strap_sync;

    // Pin idles high; a low reset value would turn power-on into a pin reset
    rss_sync #(
        .W       (1),
        .RST_VAL (1'b1)
    ) u_pin_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_async   (i_pin_reset_low),
        .o_sync    (pin_high)
    );

    rss_sync #(
        .W       (SW),
        .RST_VAL (1'b0)
    ) u_strap_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_async   (i_strap),
        .o_sync    (strap_sync)
    );

    // ========================================
    // State
    rss_pkg::rss_state_t state;
    rss_pkg::rss_kind_t  kind;
    logic [CW-1:0]       cnt;
    logic                strap_done;
    logic                ready;
    logic                read_seen;
    logic                soft_bit;
    logic                dig_bit;
    logic [2:0]          phy_bit;
    logic [CW-1:0]       phy_cnt [3];
    logic [31:0]         host_scr;
    logic [31:0]         sticky;

    logic chip_kind;
    logic in_hold;
    logic wr;
    logic rd;
    logic wr_ok;
    logic wr_hw;
    logic wr_pmt;
    logic wr_rc;
    logic dig_req;
    logic soft_req;
    logic seq_end;

    assign chip_kind = (kind == rss_pkg::RSS_KIND_POR) ||
                       (kind == rss_pkg::RSS_KIND_PIN);
    assign in_hold   = (state == rss_pkg::RSS_HOLD);
    assign seq_end   = (state == rss_pkg::RSS_LOAD) && i_loader_done;

    // ========================================
    // Bus strobes: read at request, write at the acked edge
    assign rd    = i_wb_cyc && i_wb_stb && !i_wb_we && !o_wb_ack;
    assign wr    = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack;
    // Writes count only when ready and after a first read
    assign wr_ok = wr && ready && read_seen;
    assign wr_hw  = wr_ok && (i_wb_adr == `RSS_OFS_HARDWARE_CONFIG_REG) && i_wb_sel[0];
    assign wr_pmt = wr_ok && (i_wb_adr == `RSS_OFS_POWER_MGMT_CTRL_REG) && i_wb_sel[0];
    assign wr_rc  = wr_ok && (i_wb_adr == `RSS_OFS_RESET_CONTROL_REG) && i_wb_sel[0];
    assign dig_req  = wr_rc && i_wb_dat[`RSS_RC_DIG_BIT];
    assign soft_req = wr_hw && i_wb_dat[`RSS_HW_SOFT_BIT];

    // ========================================
    // Reset sequencer
    // Pin and power-on override any sequence already running
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state <= rss_pkg::RSS_HOLD;
            kind  <= rss_pkg::RSS_KIND_POR;
            cnt   <= CW'(POR_CYC);
        end else if (!pin_high) begin
            state <= rss_pkg::RSS_HOLD;
            kind  <= rss_pkg::RSS_KIND_PIN;
            cnt   <= CW'(PIN_CYC);
        end else begin
            unique case (state)
                rss_pkg::RSS_READY: begin
                    if (dig_req) begin
                        state <= rss_pkg::RSS_HOLD;
                        kind  <= rss_pkg::RSS_KIND_DIG;
                        cnt   <= CW'(DIG_CYC);
                    end else if (soft_req) begin
                        state <= rss_pkg::RSS_HOLD;
                        kind  <= rss_pkg::RSS_KIND_SOFT;
                        cnt   <= CW'(SOFT_CYC);
                    end
                end
                rss_pkg::RSS_HOLD: begin
                    if (cnt == CW'(1)) begin
                        state <= rss_pkg::RSS_LOAD;
                    end else begin
                        cnt <= cnt - CW'(1);
                    end
                end
                rss_pkg::RSS_LOAD: begin
                    // Loader time per byte adds to the fixed hold
                    if (i_loader_done) begin
                        state <= rss_pkg::RSS_READY;
                    end
                end
            endcase
        end
    end

    // ========================================
    // Loader kick, one pulse as the hold ends
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_loader_start    <= 1'b0;
            o_loader_mac_only <= 1'b0;
        end else begin
            // Every reset kind runs the loader
            o_loader_start <= pin_high && in_hold && (cnt == CW'(1));
            // Soft reset reloads only the MAC address
            o_loader_mac_only <= (kind == rss_pkg::RSS_KIND_SOFT) &&
                                 (state != rss_pkg::RSS_READY);
        end
    end

    // ========================================
    // Strap capture once chip-level sources have released
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            strap_done <= 1'b0;
            o_strap_q  <= {SW{1'b0}};
        end else if (!pin_high) begin
            strap_done <= 1'b0;
        end else if (in_hold && chip_kind && !strap_done &&
                     cnt == CW'(1)) begin
            // Taken as the hold ends, once the strap synchroniser is filled
            strap_done <= 1'b1;
            o_strap_q  <= strap_sync;
        end
    end
    // Multi-module kinds never reach the capture branch

    // ========================================
    // Reset outputs by scope
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_rst_chip    <= 1'b1;
            o_rst_digital <= 1'b1;
            o_rst_host    <= 1'b1;
            o_rst_phy1    <= 1'b1;
            o_rst_phy2    <= 1'b1;
            o_rst_vphy    <= 1'b1;
        end else begin
            // Three levels of scope from one sequencer
            o_rst_chip    <= in_hold && chip_kind;
            o_rst_digital <= in_hold && (chip_kind ||
                             kind == rss_pkg::RSS_KIND_DIG);
            o_rst_host    <= in_hold;
            // PHYs see chip resets and their own request only
            o_rst_phy1 <= (in_hold && chip_kind) || phy_bit[0];
            o_rst_phy2 <= (in_hold && chip_kind) || phy_bit[1];
            o_rst_vphy <= (in_hold && chip_kind) || phy_bit[2];
        end
    end

    // ========================================
    // Ready flag and first-read tracking
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            ready     <= 1'b0;
            read_seen <= 1'b0;
        end else begin
            ready <= pin_high && (state == rss_pkg::RSS_READY);
            if (!ready) begin
                read_seen <= 1'b0;
            end else if (rd) begin
                read_seen <= 1'b1;
            end
        end
    end
    assign o_ready = ready;

    // ========================================
    // Reset request bits
    // Requests can only be written while ready, so no set meets a clear
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || !pin_high) begin
            dig_bit  <= 1'b0;
            soft_bit <= 1'b0;
        end else begin
            if (dig_req) begin
                dig_bit <= 1'b1;
            end else if (seq_end && kind == rss_pkg::RSS_KIND_DIG) begin
                dig_bit <= 1'b0;
            end
            if (soft_req) begin
                soft_bit <= 1'b1;
            end else if (seq_end) begin
                soft_bit <= 1'b0;
            end
        end
    end

    // ========================================
    // PHY self-clearing resets, one counter each
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || !pin_high) begin
            phy_bit <= 3'h0;
            for (int i = 0; i < 3; i++) begin
                phy_cnt[i] <= {CW{1'b0}};
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (wr_rc && i_wb_dat[`RSS_RC_PHY1_BIT + i]) begin
                    phy_bit[i] <= 1'b1;
                    phy_cnt[i] <= phy_time(i);
                end else if (phy_bit[i]) begin
                    if (phy_cnt[i] == CW'(1)) begin
                        phy_bit[i] <= 1'b0;
                    end else begin
                        phy_cnt[i] <= phy_cnt[i] - CW'(1);
                    end
                end
            end
            // Second way in for the virtual PHY
            if (wr_pmt && i_wb_dat[`RSS_PMT_VPHY_BIT]) begin
                phy_bit[2] <= 1'b1;
                phy_cnt[2] <= phy_time(2);
            end
        end
    end

    // ========================================
    // Low system scratch: any multi-module reset clears it
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || in_hold) begin
            host_scr <= `RSS_RST_WORD;
        end else if (wr_ok && i_wb_adr == `RSS_OFS_HOST_SCR) begin
            host_scr <= merge(host_scr, i_wb_dat, i_wb_sel);
        end
    end

    // ========================================
    // Sticky register: only chip-level resets clear it
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || (in_hold && chip_kind)) begin
            sticky <= `RSS_RST_WORD;
        end else if (wr_ok && i_wb_adr == `RSS_OFS_STICKY) begin
            sticky <= merge(sticky, i_wb_dat, i_wb_sel);
        end
    end

    // ========================================
    // Read mux; before ready only four registers answer with data
    logic [31:0] next_rdata;
    logic        pre_ok;
    always_comb begin
        next_rdata = 32'h0000_0000;
        pre_ok = (i_wb_adr == `RSS_OFS_HARDWARE_CONFIG_REG) ||
                 (i_wb_adr == `RSS_OFS_POWER_MGMT_CTRL_REG) ||
                 (i_wb_adr == `RSS_OFS_BYTE_TEST) ||
                 (i_wb_adr == `RSS_OFS_RESET_CONTROL_REG);
        unique case (i_wb_adr)
            `RSS_OFS_HARDWARE_CONFIG_REG: begin
                next_rdata[`RSS_HW_SOFT_BIT]  = soft_bit;
                next_rdata[`RSS_HW_STRAP_LSB +: SW] = o_strap_q;
                next_rdata[`RSS_HW_READY_BIT] = ready;
            end
            `RSS_OFS_POWER_MGMT_CTRL_REG: begin
                next_rdata[`RSS_PMT_READY_BIT] = ready;
                next_rdata[`RSS_PMT_VPHY_BIT]  = phy_bit[2];
            end
            `RSS_OFS_BYTE_TEST: next_rdata = BYTE_TEST;
            `RSS_OFS_RESET_CONTROL_REG: begin
                next_rdata[`RSS_RC_DIG_BIT]  = dig_bit;
                next_rdata[`RSS_RC_PHY1_BIT] = phy_bit[0];
                next_rdata[`RSS_RC_PHY2_BIT] = phy_bit[1];
                next_rdata[`RSS_RC_VPHY_BIT] = phy_bit[2];
            end
            `RSS_OFS_HOST_SCR: next_rdata = host_scr;
            `RSS_OFS_STICKY:   next_rdata = sticky;
            default:           next_rdata = 32'h0000_0000;
        endcase
        // Guarded reads return zero rather than stale state
        if (!ready && !pre_ok) begin
            next_rdata = 32'h0000_0000;
        end
    end

    // ========================================
    // Wishbone answer: ack one cycle after the request, for one cycle
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
        end else begin
            o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
            if (rd) begin
                o_wb_dat <= next_rdata;
            end
        end
    end

endmodule

// File: rss_top_asserts.sv
// Port-level assertions for the reset source sequencer.
`timescale 1ns/1ps

module rss_top_asserts #(
    parameter int SW = 4
) (
    input wire logic          i_clk_sys,
    input wire logic          i_rst,
    input wire logic          i_pin_reset_low,
    input wire logic          i_loader_done,
    input wire logic          i_wb_cyc,
    input wire logic          i_wb_stb,
    input wire logic          o_wb_ack,
    input wire logic          o_rst_chip,
    input wire logic          o_rst_digital,
    input wire logic          o_rst_host,
    input wire logic          o_rst_phy1,
    input wire logic          o_rst_phy2,
    input wire logic          o_rst_vphy,
    input wire logic [SW-1:0] o_strap_q,
    input wire logic          o_loader_start,
    input wire logic          o_loader_mac_only,
    input wire logic          o_ready
);

    // ========================================
    // Single clock domain, synchronous reset
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    a_ack_one_cycle: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("bus ack held past one cycle");
    a_ack_next_edge: assert property (
        i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("bus request left unanswered");
    a_chip_all_resets: assert property (o_rst_chip |->
        o_rst_digital && o_rst_host && o_rst_phy1 && o_rst_phy2 && o_rst_vphy)
        else $error("chip hold without every internal reset");
    a_digital_has_host: assert property (o_rst_digital |-> o_rst_host)
        else $error("digital hold without host port hold");
    a_hold_not_ready: assert property (o_rst_host |-> !o_ready)
        else $error("ready shown during a reset hold");
    a_strap_only_chip: assert property (
        !o_rst_chip && !$past(o_rst_chip) |-> $stable(o_strap_q))
        else $error("straps moved outside a chip-level hold");
    a_start_is_pulse: assert property (o_loader_start |=> !o_loader_start)
        else $error("loader start longer than one cycle");
    a_chip_runs_load: assert property ($fell(o_rst_chip) |->
        ($past(o_loader_start) || o_loader_start) or (##1 o_loader_start))
        else $error("chip-level reset ended without a loader run");
    a_done_gives_ready: assert property (i_loader_done |-> ##[1:3] o_ready)
        else $error("ready missing after loader finished");
    a_pin_holds_chip: assert property (
        !i_pin_reset_low |-> ##[1:5] o_rst_chip)
        else $error("low reset pin did not hold the chip");
    a_soft_scope: assert property (
        o_loader_mac_only |-> !o_rst_digital && !o_rst_chip && !o_ready)
        else $error("soft reset reached beyond host port");

endmodule

// File: test_reset_source_sequencer.sv
// Self-checking bench for the reset source sequencer.
`timescale 1ns/1ps
`include "rss_consts.svh"

module test_reset_source_sequencer;

    localparam int SW = 4;
    localparam int PHY_N = 12;
    localparam logic [8:0] A_HW = `RSS_OFS_HARDWARE_CONFIG_REG;
    localparam logic [8:0] A_PMT = `RSS_OFS_POWER_MGMT_CTRL_REG;
    localparam logic [8:0] A_SCR = `RSS_OFS_HOST_SCR;
    localparam logic [8:0] A_RC = `RSS_OFS_RESET_CONTROL_REG;
    localparam logic [8:0] A_STK = `RSS_OFS_STICKY;
    localparam logic [31:0] STK_V = 32'hC3A5_5A3C;

    logic          clk, rst, pin_n, ld_done, cyc, stb, we, ack;
    logic          r_chip, r_dig, r_host, r_p1, r_p2, r_vp;
    logic          ld_start, mac_only, ready;
    logic [SW-1:0] strap, strap_q;
    logic [8:0]    adr;
    logic [31:0]   wdat, rdat, q;
    logic [3:0]    sel;
    logic [7:0]    dly;
    int            bad_count = 0;
    int            n_tests = 0;
    int            n_loads = 0;
    int            k;

    always #20 clk = ~clk;

    rss_top #(.SW(SW), .POR_CYC(12), .PIN_CYC(10), .DIG_CYC(10),
        .SOFT_CYC(8), .PHY_CYC(PHY_N), .VPHY_CYC(PHY_N)) u_dut (
        .i_clk_sys(clk), .i_rst(rst), .i_pin_reset_low(pin_n),
        .i_strap(strap), .i_loader_done(ld_done), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat),
        .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack),
        .o_rst_chip(r_chip), .o_rst_digital(r_dig), .o_rst_host(r_host),
        .o_rst_phy1(r_p1), .o_rst_phy2(r_p2), .o_rst_vphy(r_vp),
        .o_strap_q(strap_q), .o_loader_start(ld_start),
        .o_loader_mac_only(mac_only), .o_ready(ready));

    rss_loader_model u_ldr (.i_clk_sys(clk), .i_rst(rst),
        .i_start(ld_start), .i_dly(dly), .o_done(ld_done));

    // Count loader runs seen at the port
    always @(posedge clk) if (ld_start === 1'b1) n_loads <= n_loads + 1;

    // ========================================
    // Checking and bus tasks
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Classic cycle; held until ack is sampled, then one idle cycle
    task automatic wb(input logic w, input logic [8:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        chk("bus ack", ack, 1'b1);
        @(posedge clk);
    endtask

    task automatic rd(input string nm, input logic [8:0] a,
                      input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(nm, q, e);
    endtask

    // Bounded wait, as the loader delay varies
    task automatic wait_rdy;
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        chk("ready", ready, 1'b1);
    endtask

    function automatic logic [31:0] hw(input logic [SW-1:0] s);
        return (32'h1 << `RSS_HW_READY_BIT) | (32'(s) << `RSS_HW_STRAP_LSB);
    endfunction

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ========================================
    // Test sequence
    initial begin
        {clk, cyc, stb, we, adr, wdat, sel} = '0;
        rst = 1'b1;
        pin_n = 1'b1;
        strap = 4'hA;
        dly = 8'd2;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("por hold", r_chip, 1'b1);
        rd("byte test", `RSS_OFS_BYTE_TEST, `RSS_BYTE_TEST_VAL);
        rd("pmt early", A_PMT, 32'h0);
        wait_rdy();
        chk("straps", strap_q, 4'hA);
        chk("loads", n_loads, 1);
        wb(1'b1, A_SCR, 32'h1234_5678);
        rd("write before read", A_SCR, 32'h0);
        rd("hardware_config_reg", A_HW, hw(4'hA));
        rd("pmt", A_PMT, 32'h1);
        wb(1'b1, A_STK, STK_V);
        rd("sticky", A_STK, STK_V);
        $display("test power-on done");

        // Digital reset; straps move but must not be taken
        strap <= 4'h5;
        dly <= 8'd30;
        wb(1'b1, A_RC, 32'h1);
        @(posedge clk);
        chk("dig scope", {r_chip, r_dig, r_host, r_p1, r_p2, r_vp},
            6'b011000);
        rd("dig bit busy", A_RC, 32'h1);
        wait_rdy();
        wb(1'b1, A_SCR, 32'h77);
        rd("scr after dig", A_SCR, 32'h0);
        chk("loads", n_loads, 2);
        chk("straps kept", strap_q, 4'hA);
        rd("dig bit clear", A_RC, 32'h0);
        rd("sticky dig", A_STK, STK_V);
        $display("test digital done");

        // Soft reset: host port only, loader for the MAC address
        wb(1'b1, A_SCR, 32'h55);
        wb(1'b1, A_HW, 32'h1);
        @(posedge clk);
        chk("soft scope", {r_chip, r_dig, r_host, mac_only}, 4'b0011);
        wait_rdy();
        chk("loads", n_loads, 3);
        rd("soft bit", A_HW, hw(4'hA));
        rd("scr soft", A_SCR, 32'h0);
        rd("sticky soft", A_STK, STK_V);
        $display("test soft done");

        // Each PHY reset alone; ready and loader untouched
        for (k = 1; k <= 3; k++) begin
            wb(1'b1, A_RC, 32'h1 << k);
            @(posedge clk);
            chk("phy scope", {r_dig, r_host, r_p1, r_p2, r_vp, ready},
                {2'b00, 3'b100 >> (k - 1), 1'b1});
            rd("phy bit", A_RC, 32'h1 << k);
            repeat (PHY_N) @(posedge clk);
            rd("phy clear", A_RC, 32'h0);
        end
        wb(1'b1, A_PMT, 32'h1 << `RSS_PMT_VPHY_BIT);
        @(posedge clk);
        chk("vphy pmt", r_vp, 1'b1);
        repeat (PHY_N) @(posedge clk);
        chk("loads", n_loads, 3);
        $display("test phy done");

        // Pin reset: full chip, new straps taken
        pin_n <= 1'b0;
        repeat (6) @(posedge clk);
        chk("pin hold", r_chip, 1'b1);
        pin_n <= 1'b1;
        dly <= 8'd2;
        wait_rdy();
        chk("straps new", strap_q, 4'h5);
        chk("loads", n_loads, 4);
        rd("sticky pin", A_STK, 32'h0);
        rd("unmapped", 9'h100, 32'h0);
        $display("test pin done");
        end_sim();
    end

    // Hang guard, well beyond the expected run
    initial begin
        repeat (4000) @(posedge clk);
        bad_count++;
        $display("watchdog expired");
        end_sim();
    end

endmodule

bind rss_top rss_top_asserts #(.SW(SW)) u_chk (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_pin_reset_low(i_pin_reset_low), .i_loader_done(i_loader_done),
    .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack),
    .o_rst_chip(o_rst_chip), .o_rst_digital(o_rst_digital),
    .o_rst_host(o_rst_host), .o_rst_phy1(o_rst_phy1),
    .o_rst_phy2(o_rst_phy2), .o_rst_vphy(o_rst_vphy),
    .o_strap_q(o_strap_q), .o_loader_start(o_loader_start),
    .o_loader_mac_only(o_loader_mac_only), .o_ready(o_ready));
